// *** hw/aaf_params.svh ***
`ifndef AAF_PARAMS_SVH
`define AAF_PARAMS_SVH

// ==========================================
// word layout
`define AAF_RESULT_W       24
`define AAF_COUNT_W        16
`define AAF_WORD_W         40
// ==========================================
// averaging limits
`define AAF_N_W            17
`define AAF_MAX_N          17'h10000
`define AAF_MAX_SHIFT      5'h10
`define AAF_POS_FULL       24'h7fffff
`define AAF_NEG_FULL       24'h800000
// ==========================================
// serial clocks per conversion cycle for a full read
`define AAF_SCK_W          5
`define AAF_MIN_FULL_READ  5'h14
// ==========================================
// timing
`define AAF_CONV_TIME_NS   392
`define AAF_CLK_PERIOD_NS  8
`define AAF_CONV_CNT_W     8

`endif

// *** hw/aaf_pkg.sv ***
`include "aaf_params.svh"

package aaf_pkg;
	// ==========================================
	// types
	typedef enum logic {
		AAF_CONV_IDLE = 1'b0,
		AAF_CONV_BUSY = 1'b1
	} aaf_conv_e;

	typedef struct packed {
		logic [`AAF_RESULT_W-1:0] result;
		logic [`AAF_COUNT_W-1:0]  count;
	} aaf_word_s;
endpackage

// *** hw/aaf_sync.sv ***
`timescale 1ns/1ns

module aaf_sync #(
	parameter int W = 2
) (
	input  wire logic         clock,  // device clock
	input  wire logic         rst_n,  // sync reset, active low
	input  wire logic [W-1:0] d_in,   // asynchronous levels
	output logic      [W-1:0] q_out   // synchronised levels
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	if (W < 1) begin : g_chk
		$error("aaf_sync: W must be at least one");
	end

	always_comb begin
		meta_nxt = d_in;
		q_nxt    = meta_r;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q_out = q_r;
endmodule

// *** hw/aaf_filter.sv ***
`timescale 1ns/1ns
`include "aaf_params.svh"

// Functional notes
// - averages 1 to 65536 results, no configuration
// - result register holds latest 24-bit conversion
// - filter loads averages into output shift register
// - read every cycle gives single unaveraged result
// - 20 clocks per cycle give 20-bit result
// - accumulate until read; read restarts the average
// - non power of two divides by next power
// - 1 to 19 clocks per cycle preserve output
// - first clock rising edge starts read, resets filter
// - 0 or over 19 clocks end read, reload
// - average spans read start to next start
// - 16-bit count N minus one follows result
// - weight stops at 65536, output may saturate
// - conversion cannot restart, busy high throughout

module aaf_filter
	import aaf_pkg::*;
#(
	parameter int CONV_CYCLES = `AAF_CONV_TIME_NS / `AAF_CLK_PERIOD_NS
) (
	input  wire logic                     clock,          // 125 MHz
	input  wire logic                     rst_n,          // sync reset
	input  wire logic                     convert_start,  // pin
	input  wire logic                     sck,            // serial clock
	input  wire logic [`AAF_RESULT_W-1:0] core_result,    // core output
	output logic                          busy,           // converting
	output logic                          sdo             // serial data
);
	localparam int ACC_W    = `AAF_RESULT_W + `AAF_N_W + 1;
	localparam int CONV_DM1 = CONV_CYCLES - 1;
	// cycles of busy after its first two, up to and including its last cycle
	localparam int BUSY_GAP = CONV_CYCLES - 2;

	if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : g_chk
		$error("aaf_filter: CONV_CYCLES out of range");
	end

	// ==========================================
	// weight shift: ceil(log2(n)), capped at the largest weight
	function automatic logic [4:0] aaf_weight_shift(
		input logic [`AAF_N_W-1:0] n
	);
		logic [4:0] s;
		s = 5'h0;
		for (int i = 0; i < `AAF_N_W - 1; i++) begin
			if ((`AAF_N_W'(1) << i) < n) begin
				s = 5'(i + 1);
			end
		end
		if (s > `AAF_MAX_SHIFT) begin
			s = `AAF_MAX_SHIFT;
		end
		return s;
	endfunction

	// ==========================================
	// pin synchronisers and edge detection
	logic [1:0] pins_s;
	logic       cs_prev_r;
	logic       cs_prev_nxt;
	logic       sck_prev_r;
	logic       sck_prev_nxt;
	logic       cs_rise;
	logic       sck_rise;

	aaf_sync #(
		.W(2)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d_in ({sck, convert_start}),
		.q_out(pins_s)
	);

	always_comb begin
		cs_prev_nxt  = pins_s[0];
		sck_prev_nxt = pins_s[1];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cs_prev_r  <= 1'b0;
			sck_prev_r <= 1'b0;
		end else begin
			cs_prev_r  <= cs_prev_nxt;
			sck_prev_r <= sck_prev_nxt;
		end
	end

	assign cs_rise  = pins_s[0] & ~cs_prev_r;
	assign sck_rise = pins_s[1] & ~sck_prev_r;

	// ==========================================
	// conversion timing
	aaf_conv_e                  conv_r;
	aaf_conv_e                  conv_nxt;
	logic [`AAF_CONV_CNT_W-1:0] cnt_r;
	logic [`AAF_CONV_CNT_W-1:0] cnt_nxt;
	logic                       done;

	always_comb begin
		conv_nxt = conv_r;
		cnt_nxt  = cnt_r;
		done     = 1'b0;
		case (conv_r)
			AAF_CONV_IDLE: begin
				if (cs_rise) begin
					conv_nxt = AAF_CONV_BUSY;
					cnt_nxt  = `AAF_CONV_CNT_W'(CONV_DM1);
				end
			end
			AAF_CONV_BUSY: begin
				// edges on convert_start are ignored here
				if (cnt_r == '0) begin
					conv_nxt = AAF_CONV_IDLE;
					done     = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: conv_nxt = AAF_CONV_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conv_r <= AAF_CONV_IDLE;
			cnt_r  <= '0;
		end else begin
			conv_r <= conv_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign busy = conv_r;

	// ==========================================
	// filter, read tracking and output register
	logic        [`AAF_RESULT_W-1:0] result_r;
	logic        [`AAF_RESULT_W-1:0] result_nxt;
	logic signed [ACC_W-1:0]         acc_r;
	logic signed [ACC_W-1:0]         acc_nxt;
	logic        [`AAF_N_W-1:0]      n_r;
	logic        [`AAF_N_W-1:0]      n_nxt;
	logic        [`AAF_SCK_W-1:0]    sck_cnt_r;
	logic        [`AAF_SCK_W-1:0]    sck_cnt_nxt;
	logic                            reading_r;
	logic                            reading_nxt;
	aaf_word_s                       io_r;
	aaf_word_s                       io_nxt;
	logic signed [ACC_W-1:0]         sum;
	logic signed [ACC_W-1:0]         avg;
	logic        [`AAF_N_W-1:0]      n_inc;
	aaf_word_s                       load_word;
	logic                            reload;
	logic                            read_start;

	localparam logic signed [ACC_W-1:0] POS_FS =
		{{(ACC_W-`AAF_RESULT_W){1'b0}}, `AAF_POS_FULL};
	localparam logic signed [ACC_W-1:0] NEG_FS =
		{{(ACC_W-`AAF_RESULT_W){1'b1}}, `AAF_NEG_FULL};

	always_comb begin
		sum = acc_r + {{(ACC_W-`AAF_RESULT_W){core_result[`AAF_RESULT_W-1]}},
			core_result};
		// n holds at the cap while the sum keeps growing
		n_inc = (n_r == `AAF_MAX_N) ? n_r : n_r + 1'b1;
		avg   = sum >>> aaf_weight_shift(n_inc);
		if (avg > POS_FS) begin
			load_word.result = `AAF_POS_FULL;
		end else if (avg < NEG_FS) begin
			load_word.result = `AAF_NEG_FULL;
		end else begin
			load_word.result = avg[`AAF_RESULT_W-1:0];
		end
		// n_inc never exceeds 65536, so n-1 fits in 16 bits
		load_word.count = n_inc[`AAF_COUNT_W-1:0] - 1'b1;

		// 0 or 20+ edges end the read; 1..19 preserve
		reload     = done && (sck_cnt_r == '0 ||
			sck_cnt_r >= `AAF_MIN_FULL_READ);
		// an edge landing on a reload opens the next read at once
		read_start = sck_rise && (!reading_r || reload);

		result_nxt  = result_r;
		acc_nxt     = acc_r;
		n_nxt       = n_r;
		sck_cnt_nxt = sck_cnt_r;
		reading_nxt = reading_r;
		io_nxt      = io_r;

		if (done) begin
			result_nxt  = core_result;
			acc_nxt     = sum;
			n_nxt       = n_inc;
			sck_cnt_nxt = sck_rise ? `AAF_SCK_W'(1) : '0;
			if (reload) begin
				reading_nxt = 1'b0;
			end
		end else if (sck_rise && sck_cnt_r < `AAF_MIN_FULL_READ) begin
			sck_cnt_nxt = sck_cnt_r + 1'b1;
		end

		// a new average starts with the next conversion
		if (read_start) begin
			acc_nxt     = '0;
			n_nxt       = '0;
			reading_nxt = 1'b1;
		end

		if (reload) begin
			io_nxt = load_word;
		end else if (sck_rise) begin
			io_nxt = {io_r[`AAF_WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			result_r  <= '0;
			acc_r     <= '0;
			n_r       <= '0;
			sck_cnt_r <= '0;
			reading_r <= 1'b0;
			io_r      <= '0;
		end else begin
			result_r  <= result_nxt;
			acc_r     <= acc_nxt;
			n_r       <= n_nxt;
			sck_cnt_r <= sck_cnt_nxt;
			reading_r <= reading_nxt;
			io_r      <= io_nxt;
		end
	end

	assign sdo = io_r[`AAF_WORD_W-1];

	// ==========================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_busy_length: assert property (
		$rose(busy) |-> busy [*2] ##(BUSY_GAP) busy ##1 !busy)
		else $error("busy width wrong");
	a_busy_countdown: assert property (
		busy && cnt_r != '0 |=> busy && cnt_r == $past(cnt_r) - 1'b1)
		else $error("conversion restarted or stalled");
	a_result_load: assert property (
		done |=> result_r == $past(core_result) && !busy)
		else $error("result register not loaded");
	a_io_preserve: assert property (
		done && !sck_rise && sck_cnt_r != '0 &&
		sck_cnt_r < `AAF_MIN_FULL_READ |=> io_r == $past(io_r))
		else $error("output register changed in partial read");
	a_read_end: assert property (
		done && !sck_rise && (sck_cnt_r == '0 ||
		sck_cnt_r >= `AAF_MIN_FULL_READ) |=> !reading_r && n_r != '0)
		else $error("read not terminated");
	a_read_reset: assert property (
		sck_rise && !reading_r |=> reading_r && acc_r == '0 && n_r == '0)
		else $error("read start did not reset filter");
	a_single_pass: assert property (
		done && reload && n_r == '0 |=>
		io_r.result == $past(core_result) && io_r.count == '0)
		else $error("single result not transparent");
	a_shift_msb: assert property (
		sck_rise && !reload |=> sdo == $past(io_r[`AAF_WORD_W-2]))
		else $error("serial shift out of order");
	// a read start clears n while the word still carries the old count
	a_n_cap: assert property (
		n_r <= `AAF_MAX_N && (reading_r || n_r == '0 ||
		io_r.count == `AAF_COUNT_W'(n_r - 1'b1)))
		else $error("sample count past cap");
	a_sck_count: assert property (
		sck_cnt_r <= `AAF_MIN_FULL_READ)
		else $error("clock count past full-read limit");
endmodule

// *** test/aaf_host_model.sv ***
`timescale 1ns/1ns
`include "aaf_params.svh"

// ==========================================
// host: serial master that clocks the word out
module aaf_host_model (
	output logic      sck,  // serial clock, parked low
	input  wire logic sdo   // serial data from device
);
	logic [`AAF_WORD_W-1:0] cap;  // newest bit in bit 0

	initial begin
		sck = 1'b0;
		cap = '0;
	end

	// callers end a read with 0 or 20+ edges, give one edge or more in
	// every cycle of a split read, and read only between conversions
	task automatic pulses(input int n);
		repeat (n) begin
			cap = {cap[`AAF_WORD_W-2:0], sdo};
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
	endtask
endmodule

// *** test/aaf_filter_test.sv ***
`timescale 1ns/1ns
`include "aaf_params.svh"

module aaf_filter_test
	import aaf_pkg::*;
;
	localparam int CONV = 8;
	logic                     clock = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     convert_start = 1'b0;
	logic [`AAF_RESULT_W-1:0] core_result = '0;
	logic                     sck;
	logic                     busy;
	logic                     sdo;
	int                       errors = 0;
	int                       n_checks = 0;
	int                       cycles = 0;
	aaf_word_s                w;

	always #4 clock = ~clock;

	aaf_filter #(.CONV_CYCLES(CONV)) u_aaf_filter (
		.clock(clock), .rst_n(rst_n), .convert_start(convert_start),
		.sck(sck), .core_result(core_result), .busy(busy), .sdo(sdo));
	aaf_host_model u_aaf_host_model (.sck(sck), .sdo(sdo));

	// ==========================================
	// helpers
	task automatic chk(input logic [39:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
		end
	endtask

	// a second start edge while busy must change nothing
	task automatic conv(input logic [23:0] v);
		int n;
		n = 0;
		repeat (6) @(posedge clock);
		#1 core_result = v;
		convert_start = 1'b1;
		do begin
			@(posedge clock);
			#1 n++;
		end while (busy !== 1'b1 && n < 9);
		n = 0;
		do begin
			@(posedge clock);
			#1 convert_start = (n == 1);
			n++;
		end while (busy === 1'b1 && n < 300);
		chk(40'(n), 40'(CONV), "busy length");
	endtask

	task automatic rd(input int n, input bit clr);
		if (clr)
			u_aaf_host_model.cap = '0;
		u_aaf_host_model.pulses(n);
	endtask

	// ==========================================
	// scenarios
	task automatic t_single();
		conv(24'h5a3c91);
		rd(20, 1);
		chk(40'(u_aaf_host_model.cap[19:0]), 40'h5a3c9, "short");
		conv(24'ha1b2c3);
		rd(40, 1);
		w = '{result: 24'ha1b2c3, count: 16'h0};
		chk(u_aaf_host_model.cap, w, "single");
		$display("done t_single");
	endtask

	task automatic t_avg3();
		conv(24'h100000);
		conv(24'h200000);
		conv(24'h300003);
		rd(40, 1);
		w.result = 24'((26'h100000 + 26'h200000 + 26'h300003) >> 2);
		w.count = 16'h2;
		chk(u_aaf_host_model.cap, w, "avg3");
		$display("done t_avg3");
	endtask

	// word read over three cycles, then a silent cycle
	task automatic t_split();
		conv(24'h7f00aa);
		rd(8, 1);
		conv(24'h000010);
		rd(8, 0);
		conv(24'h000020);
		rd(24, 0);
		w = '{result: 24'h7f00aa, count: 16'h0};
		chk(u_aaf_host_model.cap, w, "split");
		conv(24'h000030);
		conv(24'h000040);
		rd(40, 1);
		w.result = 24'((26'h10 + 26'h20 + 26'h30 + 26'h40) >> 2);
		w.count = 16'h3;
		chk(u_aaf_host_model.cap, w, "after");
		$display("done t_split");
	endtask

	// ==========================================
	// verdict
	task automatic results();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			results();
		end
	end

	initial begin
		repeat (4) @(posedge clock);
		#1 rst_n = 1'b1;
		t_single();
		t_avg3();
		t_split();
		results();
	end
endmodule
